// ===== design/adcam_pkg.sv
// Constants, register map and types for the automatic-measurement control block
package adcam_pkg;

  // Register access ports
  localparam logic [7:0] I2C_PAGE_REGS = 8'h00;
  localparam logic [7:0] UC_BASE_HI = 8'hA0;

  // Register byte addresses on page 0; the local bus adds the base above
  localparam logic [7:0] OFS_CFG = 8'hD1;
  localparam logic [7:0] OFS_IEN = 8'hD2;
  localparam logic [7:0] OFS_AUX1 = 8'hD3;
  localparam logic [7:0] OFS_AUX2 = 8'hD4;
  localparam logic [7:0] OFS_AUX3 = 8'hD5;
  localparam logic [7:0] OFS_AUX4 = 8'hD6;
  localparam logic [7:0] OFS_RAIL = 8'hD7;
  localparam logic [7:0] OFS_CHG = 8'hD8;

  // Register file geometry
  localparam int NUM_REGS = 8;
  localparam logic [7:0] NUM_REGS_B = 8'h08;
  localparam int IDX_CFG = 0;
  localparam int IDX_IEN = 1;
  localparam int IDX_SCH0 = 2;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] DATA_ZERO = 8'h00;

  // Field positions
  localparam int CFG_MODE_BIT = 0;
  localparam int CFG_PWR_BIT = 2;
  localparam int SCH_EN_BIT = 0;
  localparam int SCH_EXP_LSB = 4;
  localparam int SCH_EXP_MSB = 7;

  // Alert positions, shared by status input and enable register
  localparam int ALR_PEN = 0;
  localparam int ALR_TEMP_OVER = 1;
  localparam int ALR_TEMP_UNDER = 2;
  localparam int ALR_BAT_OVER = 3;
  localparam int ALR_BAT_UNDER = 4;
  localparam int ALR_RAIL_OVER = 5;
  localparam int ALR_RAIL_UNDER = 6;
  localparam int ALR_BAT_CRIT = 7;

  // Scheduled sources, index order is service priority (0 first)
  localparam int NUM_SRC = 6;
  localparam logic [2:0] SRC_AUX1 = 3'h0;
  localparam logic [2:0] SRC_AUX2 = 3'h1;
  localparam logic [2:0] SRC_AUX3 = 3'h2;
  localparam logic [2:0] SRC_AUX4 = 3'h3;
  localparam logic [2:0] SRC_RAIL = 3'h4;
  localparam logic [2:0] SRC_CHG = 3'h5;

  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int MS_TIME_NS = 1000000;
  localparam int MS_CYCLES_DFLT = (MS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PER_W = 16;

  typedef enum logic [0:0] {
    ARB_IDLE = 1'b0,
    ARB_REQ = 1'b1
  } adcam_arb_e;

endpackage

// ===== design/adcam_sched.sv
// Per-source periodic scheduler counting millisecond ticks
`timescale 1ns/1ps
module adcam_sched (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_en,
  input wire logic [3:0] i_exp,
  input wire logic i_ms_tick,
  output logic o_due
);
  import adcam_pkg::*;

  logic [PER_W-1:0] cnt_q;
  logic [PER_W-1:0] cnt_d;
  logic due_q;
  logic due_d;
  logic [PER_W-1:0] limit;
  logic at_limit;

  // Period is two to the exponent ticks; >= also copes with a shrunk exponent
  assign limit = (16'h0001 << i_exp) - 16'h0001;
  assign at_limit = cnt_q >= limit;
  assign cnt_d = !i_en ? 16'h0000 : (i_ms_tick ? (at_limit ? 16'h0000 : cnt_q + 16'h0001) : cnt_q);
  assign due_d = i_en && i_ms_tick && at_limit;
  assign o_due = due_q;

  // Counter and due pulse
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_q <= 16'h0000;
      due_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      due_q <= due_d;
    end
  end

  a_due_on_limit: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (i_en && i_ms_tick && cnt_q == limit) |=> o_due) else $error("due pulse missing at period end");
  a_due_needs_en: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    o_due |-> ($past(i_en) && $past(i_ms_tick))) else $error("due pulse without enable and tick");
endmodule

// ===== design/adcam_arb.sv
// Fixed-priority queue of due measurements toward the converter
`timescale 1ns/1ps
module adcam_arb (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic [adcam_pkg::NUM_SRC-1:0] i_due,
  input wire logic i_ack,
  output logic o_req,
  output logic [2:0] o_src,
  output logic [adcam_pkg::NUM_SRC-1:0] o_pending
);
  import adcam_pkg::*;

  adcam_arb_e st_q;
  adcam_arb_e st_d;
  logic [NUM_SRC-1:0] pend_q;
  logic [NUM_SRC-1:0] pend_d;
  logic [NUM_SRC-1:0] clr;
  logic [2:0] src_q;
  logic [2:0] src_d;
  logic [2:0] first;
  logic take;
  logic done;

  // Lowest index pending wins
  function automatic logic [2:0] first_one(input logic [NUM_SRC-1:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  assign first = first_one(pend_q);
  assign take = (st_q == ARB_IDLE) && (|pend_q);
  assign done = (st_q == ARB_REQ) && i_ack;
  assign clr = done ? (6'h01 << src_q) : 6'h00;
  // A due that lands with its own grant stays queued: set beats clear
  assign pend_d = (pend_q & ~clr) | i_due;
  assign src_d = take ? first : src_q;
  assign o_req = (st_q == ARB_REQ);
  assign o_src = src_q;
  assign o_pending = pend_q;

  // Request state
  always_comb begin
    st_d = st_q;
    case (st_q)
      ARB_IDLE: begin
        if (take) begin
          st_d = ARB_REQ;
        end
      end
      ARB_REQ: begin
        if (i_ack) begin
          st_d = ARB_IDLE;
        end
      end
      default: begin
        st_d = ARB_IDLE;
      end
    endcase
  end

  // Queue registers
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      st_q <= ARB_IDLE;
      pend_q <= 6'h00;
      src_q <= 3'h0;
    end else begin
      st_q <= st_d;
      pend_q <= pend_d;
      src_q <= src_d;
    end
  end

  a_due_not_lost: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (|i_due) |=> ((pend_q & $past(i_due)) == $past(i_due))) else $error("due measurement dropped");
  a_fixed_prio: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    $rose(o_req) |-> (($past(pend_q) & ((6'h01 << o_src) - 6'h01)) == 6'h00)) else $error("priority order broken");
  a_req_holds: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (o_req && !i_ack) |=> (o_req && $stable(o_src))) else $error("request withdrawn before ack");
endmodule

// ===== design/adcam_top.sv
// Configuration registers, schedulers and interrupt gating of the measurement converter
`timescale 1ns/1ps
module adcam_top #(
  parameter int MS_CYCLES = adcam_pkg::MS_CYCLES_DFLT
) (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  // Register port from the I2C slave front end
  input wire logic [7:0] i_i2c_page,
  input wire logic [7:0] i_i2c_addr,
  input wire logic i_i2c_wr,
  input wire logic i_i2c_rd,
  input wire logic [7:0] i_i2c_wdata,
  output logic [7:0] o_i2c_rdata,
  output logic o_i2c_rvalid,
  // Embedded controller local bus
  input wire logic [15:0] i_uc_addr,
  input wire logic i_uc_wr,
  input wire logic i_uc_rd,
  input wire logic [7:0] i_uc_wdata,
  output logic [7:0] o_uc_rdata,
  output logic o_uc_rvalid,
  // Alert conditions from the comparators
  input wire logic [7:0] i_alert_status,
  output logic o_irq,
  // Converter control
  output logic o_touch_or_general_select,
  output logic o_converter_power_policy,
  output logic o_meas_req,
  output logic [2:0] o_meas_src,
  input wire logic i_meas_ack,
  output logic [adcam_pkg::NUM_SRC-1:0] o_meas_pending
);
  import adcam_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  logic [7:0] i2c_off;
  logic [7:0] uc_off;
  logic i2c_hit;
  logic uc_hit;
  logic [2:0] i2c_idx;
  logic [2:0] uc_idx;

  // Both ports land on one register file; I2C only sees it on page 0
  assign i2c_off = i_i2c_addr - OFS_CFG;
  assign uc_off = i_uc_addr[7:0] - OFS_CFG;
  assign i2c_hit = (i_i2c_page == I2C_PAGE_REGS) && (i2c_off < NUM_REGS_B);
  assign uc_hit = (i_uc_addr[15:8] == UC_BASE_HI) && (uc_off < NUM_REGS_B);
  assign i2c_idx = i2c_off[2:0];
  assign uc_idx = uc_off[2:0];

  ////////////////////////////////////////////////////////////////////////////
  // Register file

  logic [7:0] reg_q [NUM_REGS];
  logic [NUM_REGS-1:0] i2c_we;
  logic [NUM_REGS-1:0] uc_we;

  // One flop byte per register; all bits stored, reserved ones included
  for (genvar k = 0; k < NUM_REGS; k++) begin : g_reg
    logic [7:0] reg_d;
    // Same-cycle writes to one register: the I2C host wins
    assign i2c_we[k] = i_i2c_wr && i2c_hit && (i2c_idx == 3'(k));
    assign uc_we[k] = i_uc_wr && uc_hit && (uc_idx == 3'(k));
    assign reg_d = i2c_we[k] ? i_i2c_wdata : (uc_we[k] ? i_uc_wdata : reg_q[k]);

    // Every field clears to zero at reset
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
        reg_q[k] <= REG_RST;
      end else begin
        reg_q[k] <= reg_d;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read ports

  logic [7:0] i2c_rd_d;
  logic [7:0] uc_rd_d;
  logic [7:0] i2c_rdata_q;
  logic [7:0] uc_rdata_q;
  logic i2c_rvalid_q;
  logic uc_rvalid_q;

  // Unmapped addresses answer zero so a stray read is harmless
  assign i2c_rd_d = i2c_hit ? reg_q[i2c_idx] : DATA_ZERO;
  assign uc_rd_d = uc_hit ? reg_q[uc_idx] : DATA_ZERO;
  assign o_i2c_rdata = i2c_rdata_q;
  assign o_i2c_rvalid = i2c_rvalid_q;
  assign o_uc_rdata = uc_rdata_q;
  assign o_uc_rvalid = uc_rvalid_q;

  // Read data is held until the next read on that port
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      i2c_rdata_q <= DATA_ZERO;
      uc_rdata_q <= DATA_ZERO;
      i2c_rvalid_q <= 1'b0;
      uc_rvalid_q <= 1'b0;
    end else begin
      i2c_rdata_q <= i_i2c_rd ? i2c_rd_d : i2c_rdata_q;
      uc_rdata_q <= i_uc_rd ? uc_rd_d : uc_rdata_q;
      i2c_rvalid_q <= i_i2c_rd;
      uc_rvalid_q <= i_uc_rd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode and power outputs

  logic [7:0] cfg;
  logic [7:0] ien;

  // Straight from the register flops, no extra stage of latency
  assign cfg = reg_q[IDX_CFG];
  assign ien = reg_q[IDX_IEN];
  assign o_touch_or_general_select = cfg[CFG_MODE_BIT];
  assign o_converter_power_policy = cfg[CFG_PWR_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt gating

  logic [7:0] irq_gated;
  logic irq_q;

  // Status is a live level; nothing here is sticky, so the line drops with the cause
  assign irq_gated[ALR_PEN] = i_alert_status[ALR_PEN] & ien[ALR_PEN];
  assign irq_gated[ALR_TEMP_OVER] = i_alert_status[ALR_TEMP_OVER] & ien[ALR_TEMP_OVER];
  assign irq_gated[ALR_TEMP_UNDER] = i_alert_status[ALR_TEMP_UNDER] & ien[ALR_TEMP_UNDER];
  assign irq_gated[ALR_BAT_OVER] = i_alert_status[ALR_BAT_OVER] & ien[ALR_BAT_OVER];
  assign irq_gated[ALR_BAT_UNDER] = i_alert_status[ALR_BAT_UNDER] & ien[ALR_BAT_UNDER];
  assign irq_gated[ALR_RAIL_OVER] = i_alert_status[ALR_RAIL_OVER] & ien[ALR_RAIL_OVER];
  assign irq_gated[ALR_RAIL_UNDER] = i_alert_status[ALR_RAIL_UNDER] & ien[ALR_RAIL_UNDER];
  assign irq_gated[ALR_BAT_CRIT] = i_alert_status[ALR_BAT_CRIT] & ien[ALR_BAT_CRIT];
  assign o_irq = irq_q;

  // Registered so the pin is glitch free
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |irq_gated;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond tick

  logic [PER_W-1:0] ms_cnt_q;
  logic ms_last;
  logic ms_tick_q;

  // Free-running so all schedulers share one time base
  assign ms_last = ms_cnt_q == PER_W'(MS_CYCLES - 1);

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      ms_cnt_q <= 16'h0000;
      ms_tick_q <= 1'b0;
    end else begin
      ms_cnt_q <= ms_last ? 16'h0000 : ms_cnt_q + 16'h0001;
      ms_tick_q <= ms_last;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Schedulers, one per source in priority order

  logic [NUM_SRC-1:0] sch_en;
  logic [NUM_SRC-1:0] sch_due;

  // Aux 1..4, rail, charge current sit at consecutive register slots
  for (genvar s = 0; s < NUM_SRC; s++) begin : g_sch
    logic [7:0] sch_reg;
    assign sch_reg = reg_q[IDX_SCH0 + s];
    assign sch_en[s] = sch_reg[SCH_EN_BIT];

    // Counter per source, so no source shifts another's phase
    adcam_sched u_sched (
      .i_clk_sys(i_clk_sys),
      .i_rstn(i_rstn),
      .i_en(sch_en[s]),
      .i_exp(sch_reg[SCH_EXP_MSB:SCH_EXP_LSB]),
      .i_ms_tick(ms_tick_q),
      .o_due(sch_due[s])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Measurement request queue

  // Converter acks a request when it starts that conversion
  adcam_arb u_arb (
    .i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn),
    .i_due(sch_due),
    .i_ack(i_meas_ack),
    .o_req(o_meas_req),
    .o_src(o_meas_src),
    .o_pending(o_meas_pending)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  // Any enabled alert shows on the pin one cycle later
  a_irq_raise: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    (|(i_alert_status & ien)) |=>
    o_irq)
    else $error("enabled alert did not raise irq");

  // Raw status with no enable must never leak to the pin
  a_irq_quiet: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    ((i_alert_status & ien) == 8'h00) |=>
    !o_irq)
    else $error("irq without enabled alert");

  // Pen contact alone is silent while its enable is clear
  a_pen_masked: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    (i_alert_status == 8'h01 && !ien[ALR_PEN]) |=>
    !o_irq)
    else $error("masked pen contact raised irq");

  // Critical battery has its own gate in the top bit
  a_crit_gate: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    (i_alert_status == 8'h80 && ien == 8'h80) |=>
    o_irq)
    else $error("critical battery irq lost");

  // Every config bit is stored, reserved ones included
  a_i2c_cfg_write: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    (i_i2c_wr && i_i2c_page == 8'h00 && i_i2c_addr == OFS_CFG) |=>
    (cfg == $past(i_i2c_wdata) && o_touch_or_general_select == $past(i_i2c_wdata[0])))
    else $error("config write not applied");

  // Local bus write lands unless the host hit the same byte
  a_uc_cfg_write: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    (i_uc_wr && i_uc_addr == 16'hA0D1 && !i2c_we[IDX_CFG]) |=>
    (o_converter_power_policy == $past(i_uc_wdata[2]) && cfg == $past(i_uc_wdata)))
    else $error("local bus config write not applied");

  // Enable register written from the host takes effect next cycle
  a_ien_write: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    (i_i2c_wr && i_i2c_page == 8'h00 && i_i2c_addr == OFS_IEN) |=>
    (ien == $past(i_i2c_wdata)))
    else $error("enable write not applied");

  // Read returns the value before any same-cycle write
  a_uc_read_back: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    (i_uc_rd && i_uc_addr == 16'hA0D8) |=>
    (o_uc_rvalid && o_uc_rdata == $past(reg_q[7])))
    else $error("local bus read wrong");

  // Reads off page 0 answer zero rather than alias a register
  a_unmapped_zero: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    (i_i2c_rd && i_i2c_page != 8'h00) |=>
    (o_i2c_rvalid && o_i2c_rdata == 8'h00))
    else $error("off-page read not zero");

  // Valid answers exactly one cycle after each read strobe
  a_rvalid_pulse: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    1'b1 |=>
    (o_i2c_rvalid == $past(i_i2c_rd) && o_uc_rvalid == $past(i_uc_rd)))
    else $error("read valid not one cycle after strobe");

  // Disabled schedulers never produce a due
  a_disabled_idle: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    (sch_en == 6'h00) [*2] |->
    (sch_due == 6'h00))
    else $error("disabled source fell due");

  // Tick is one cycle wide; MS_CYCLES must stay at two or more
  a_ms_spacing: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    ms_tick_q |=>
    !ms_tick_q)
    else $error("tick repeated back to back");

  // A request always names a source still marked pending
  a_req_pending: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    o_meas_req |->
    o_meas_pending[o_meas_src])
    else $error("request without pending source");

  // Ack ends the request; the next one waits an idle cycle
  a_ack_ends_req: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    (o_meas_req && i_meas_ack) |=>
    !o_meas_req)
    else $error("request kept after ack");

  // Main scenarios reached
  c_touch_mode: cover property (@(posedge i_clk_sys) disable iff (!i_rstn)
    $rose(o_touch_or_general_select));

  c_irq_pen: cover property (@(posedge i_clk_sys) disable iff (!i_rstn)
    $rose(o_irq) && i_alert_status[ALR_PEN]);

  c_two_due: cover property (@(posedge i_clk_sys) disable iff (!i_rstn)
    $countones(sch_due) > 1);

  c_req_served: cover property (@(posedge i_clk_sys) disable iff (!i_rstn)
    o_meas_req ##1 i_meas_ack);

  c_all_pending: cover property (@(posedge i_clk_sys) disable iff (!i_rstn)
    o_meas_pending == 6'h3F);
endmodule

// ===== verification/adcam_conv_model.sv
// Converter-side responder that acknowledges measurement requests
`timescale 1ns/1ps
module adcam_conv_model (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_meas_req,
  input wire logic i_hold,
  input wire logic [3:0] i_delay,
  output logic o_ack
);
  logic [3:0] wait_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Ack after a chosen wait; hold models a converter busy for a long time
  // Driven on the falling edge so the block samples a settled one-cycle pulse
  always @(negedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      wait_q <= 4'h0;
      o_ack <= 1'b0;
    end else if (o_ack) begin
      o_ack <= 1'b0; // Pulse only, req drops after it
      wait_q <= 4'h0;
    end else if (i_meas_req && !i_hold) begin
      if (wait_q == i_delay) begin
        o_ack <= 1'b1;
      end else begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end
endmodule

// ===== verification/adcam_top_tb.sv
// Self-checking bench for the automatic-measurement control block
`timescale 1ns/1ps
module adcam_top_tb;
  import adcam_pkg::*;
  localparam int MS = 8;
  localparam int LIMIT = 6000;
  logic clk, rstn, i2c_wr, i2c_rd, uc_wr, uc_rd, hold, ack, req, req_prev;
  logic i2c_rvalid, uc_rvalid, irq, touch, power;
  logic [7:0] page, i2c_addr, i2c_wdata, i2c_rdata, uc_wdata, uc_rdata, status, rd;
  logic [15:0] uc_addr;
  logic [2:0] src;
  logic [NUM_SRC-1:0] pend;
  logic [3:0] delay;
  logic [7:0] cfg_v [4] = '{8'h01, 8'h04, 8'hFA, 8'h05};
  logic [2:0] src_log [$];
  int cyc_log [$];
  int bad_count, samples_checked, cyc, j;

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  adcam_top #(.MS_CYCLES(MS)) u_dut (
    .i_clk_sys(clk), .i_rstn(rstn), .i_i2c_page(page), .i_i2c_addr(i2c_addr), .i_i2c_wr(i2c_wr),
    .i_i2c_rd(i2c_rd), .i_i2c_wdata(i2c_wdata), .o_i2c_rdata(i2c_rdata), .o_i2c_rvalid(i2c_rvalid),
    .i_uc_addr(uc_addr), .i_uc_wr(uc_wr), .i_uc_rd(uc_rd), .i_uc_wdata(uc_wdata), .o_uc_rdata(uc_rdata),
    .o_uc_rvalid(uc_rvalid), .i_alert_status(status), .o_irq(irq), .o_touch_or_general_select(touch),
    .o_converter_power_policy(power), .o_meas_req(req), .o_meas_src(src), .i_meas_ack(ack),
    .o_meas_pending(pend)
  );

  adcam_conv_model u_conv (
    .i_clk_sys(clk), .i_rstn(rstn), .i_meas_req(req), .i_hold(hold), .i_delay(delay), .o_ack(ack)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Request log and hang guard, sampled at the falling edge where outputs have settled
  always @(negedge clk) begin
    cyc++;
    if (req === 1'b1 && req_prev !== 1'b1) begin
      src_log.push_back(src);
      cyc_log.push_back(cyc);
    end
    req_prev = req;
    if (cyc == LIMIT) begin
      bad_count++;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Comparisons and verdict
  task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check_bit(input string name, input logic exp, input logic got);
    check8(name, {7'h00, exp}, {7'h00, got});
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Register port access; an idle cycle after each strobe avoids double drives
  function automatic logic [15:0] addr_of(input logic port_uc, input logic [7:0] ofs);
    return port_uc ? {UC_BASE_HI, ofs} : {I2C_PAGE_REGS, ofs};
  endfunction

  task automatic reg_write(input logic port_uc, input logic [15:0] a, input logic [7:0] d);
    page = a[15:8];
    i2c_addr = a[7:0];
    i2c_wdata = d;
    uc_addr = a;
    uc_wdata = d;
    i2c_wr = !port_uc;
    uc_wr = port_uc;
    @(negedge clk);
    i2c_wr = 1'b0;
    uc_wr = 1'b0;
    @(negedge clk);
  endtask

  task automatic reg_read(input logic port_uc, input logic [15:0] a, output logic [7:0] d);
    page = a[15:8];
    i2c_addr = a[7:0];
    uc_addr = a;
    i2c_rd = !port_uc;
    uc_rd = port_uc;
    @(negedge clk);
    i2c_rd = 1'b0;
    uc_rd = 1'b0;
    check_bit("read valid", 1'b1, port_uc ? uc_rvalid : i2c_rvalid);
    d = port_uc ? uc_rdata : i2c_rdata;
    @(negedge clk);
  endtask

  task automatic check_all_zero();
    for (int i = 0; i < NUM_REGS; i++) begin
      reg_read(1'b0, addr_of(1'b0, OFS_CFG + 8'(i)), rd);
      check8("reset value", 8'h00, rd);
      reg_read(1'b1, addr_of(1'b1, OFS_CFG + 8'(i)), rd);
      check8("reset value local", 8'h00, rd);
    end
  endtask

  // Bounded waits on the request log and on an idle request queue
  task automatic wait_reqs(input int n);
    int k;
    k = 0;
    while (src_log.size() < n && k < 400) begin
      @(negedge clk);
      k++;
    end
    check8("request count", 8'(n), 8'(src_log.size()));
  endtask

  task automatic settle();
    int k;
    k = 0;
    while ((req !== 1'b0 || pend !== '0) && k < 100) begin
      @(negedge clk);
      k++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {rstn, i2c_wr, i2c_rd, uc_wr, uc_rd, hold} = 6'h00;
    {page, i2c_addr, i2c_wdata, uc_wdata, status} = 40'h00;
    uc_addr = 16'h0000;
    delay = 4'h0;
    bad_count = 0;
    samples_checked = 0;
    repeat (16) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    check_bit("mode output", 1'b0, touch);
    check_bit("power output", 1'b0, power);
    check_bit("irq after reset", 1'b0, irq);
    check_all_zero();
    // Every bit is stored, reserved ones too, and both ports see one register file
    for (int i = 0; i < NUM_REGS; i++) begin
      reg_write(1'b0, addr_of(1'b0, OFS_CFG + 8'(i)), 8'h5A + 8'(i * 37));
      reg_read(1'b1, addr_of(1'b1, OFS_CFG + 8'(i)), rd);
      check8("i2c to local", 8'h5A + 8'(i * 37), rd);
      reg_write(1'b1, addr_of(1'b1, OFS_CFG + 8'(i)), ~(8'h5A + 8'(i * 37)));
      reg_read(1'b0, addr_of(1'b0, OFS_CFG + 8'(i)), rd);
      check8("local to i2c", ~(8'h5A + 8'(i * 37)), rd);
    end
    // Second reset in mid-run must restore every default
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    check_all_zero();
    // Mode and power outputs follow only their own bits
    for (int k = 0; k < 4; k++) begin
      reg_write(1'(k % 2), addr_of(1'(k % 2), OFS_CFG), cfg_v[k]);
      check_bit("mode output", cfg_v[k][0], touch);
      check_bit("power output", cfg_v[k][2], power);
      reg_read(1'b0, addr_of(1'b0, OFS_CFG), rd);
      check8("config readback", cfg_v[k], rd);
    end
    // Off-page and off-base accesses leave the registers alone
    reg_write(1'b0, {8'h01, OFS_CFG}, 8'hFF);
    reg_write(1'b1, {8'hA1, OFS_CFG}, 8'hFF);
    reg_read(1'b1, addr_of(1'b1, OFS_CFG), rd);
    check8("unmapped write", cfg_v[3], rd);
    reg_read(1'b1, addr_of(1'b1, 8'hD9), rd);
    check8("unmapped read", 8'h00, rd);
    reg_read(1'b0, {8'h01, OFS_CFG}, rd);
    check8("off-page read", 8'h00, rd);
    // Each alert raises the interrupt only through its own enable
    for (int i = 0; i < 8; i++) begin
      reg_write(1'(i % 2), addr_of(1'(i % 2), OFS_IEN), 8'h01 << i);
      status = 8'h01 << i;
      repeat (2) @(negedge clk);
      check_bit("irq enabled alert", 1'b1, irq);
      status = ~(8'h01 << i);
      repeat (2) @(negedge clk);
      check_bit("irq masked alerts", 1'b0, irq);
    end
    // Pen contact stays silent while only the critical enable is set
    status = 8'h01;
    repeat (2) @(negedge clk);
    check_bit("irq masked pen", 1'b0, irq);
    status = 8'h00;
    // Each source alone, exponents 0, 1 and 2, spacing in system cycles
    for (int s = 0; s < NUM_SRC; s++) begin
      src_log.delete();
      cyc_log.delete();
      reg_write(1'(s % 2), addr_of(1'(s % 2), OFS_AUX1 + 8'(s)), {4'(s % 3), 4'h1});
      wait_reqs(2);
      check8("request source", 8'(s), 8'(src_log[1]));
      check8("request spacing", 8'(MS << (s % 3)), 8'(cyc_log[1] - cyc_log[0]));
      reg_write(1'(s % 2), addr_of(1'(s % 2), OFS_AUX1 + 8'(s)), 8'h00);
      settle();
    end
    // Stalled converter: all six pile up, then drain in fixed order
    hold = 1'b1;
    delay = 4'h2;
    src_log.delete();
    for (int s = 0; s < NUM_SRC; s++) begin
      reg_write(1'(s % 2), addr_of(1'(s % 2), OFS_AUX1 + 8'(s)), 8'h31);
    end
    j = 0;
    while (pend !== 6'h3F && j < 100) begin
      @(negedge clk);
      j++;
    end
    check8("pending all", 8'h3F, {2'b00, pend});
    hold = 1'b0;
    wait_reqs(6);
    j = 1;
    for (int s = 0; s < NUM_SRC; s++) begin
      if (src_log.size() > 0 && 3'(s) !== src_log[0]) begin
        check8("service order", 8'(s), 8'(src_log[j]));
        j++;
      end
    end
    for (int s = 0; s < NUM_SRC; s++) begin
      reg_write(1'b0, addr_of(1'b0, OFS_AUX1 + 8'(s)), 8'h00);
    end
    settle();
    close_out();
  end
endmodule
